// File: core/psl_divider.sv
`timescale 1ns/1ps
module psl_divider
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic hold,
   input wire logic [psl_pkg::CNT_W-1:0] ratio,
   output logic pulse
);
   logic [psl_pkg::CNT_W-1:0] count_reg;
   logic pulse_reg;

   // Ratio zero is treated as one so the divider never stalls
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         count_reg <= '0;
         pulse_reg <= 1'b0;
      end
      else if (hold)
      begin
         count_reg <= ratio;
         pulse_reg <= 1'b0;
      end
      else if (tick)
      begin
         if (count_reg <= 14'h0001)
         begin
            count_reg <= ratio; // [RULE_15]
            pulse_reg <= 1'b1;
         end
         else
         begin
            count_reg <= count_reg - 14'h0001;
            pulse_reg <= 1'b0;
         end
      end
      else
         pulse_reg <= 1'b0;
   end

   assign pulse = pulse_reg;
endmodule

// File: core/psl_loader_top.sv
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module psl_loader_top
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic serialClock,
   input wire logic serialData,
   input wire logic latchLoadStrobe,
   input wire logic powerEnable,
   input wire logic refIn,
   input wire logic rfIn,
   output logic pumpUp,
   output logic pumpDown,
   output logic pumpOutputHighZ,
   output logic [psl_pkg::CUR_W-1:0] pumpCurrentCode,
   output logic poweredDown,
   input wire logic [psl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [psl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   psl_word_if wordBus ();

   logic [23:0] refLatch_reg;
   logic [23:0] mainLatch_reg;
   logic [23:0] funcLatch_reg;
   logic [23:0] initLatch_reg;
   logic [31:0] ctrl_reg;
   logic [3:0] seen_reg;
   logic armed_reg;
   logic resetPulse_reg;
   logic progDown_reg;
   logic [2:0] pinA_reg;
   logic [2:0] pinB_reg;
   logic [1:0] edgePrev_reg;
   psl_pkg::psl_pwr_e pwr_reg;
   logic [psl_pkg::SETTLE_W-1:0] settle_reg;
   logic up_reg;
   logic down_reg;
   logic highZ_reg;
   logic [psl_pkg::CUR_W-1:0] current_reg;
   logic poweredDown_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic [psl_pkg::ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   logic [1:0] sel;
   logic commitOk;
   logic isRef;
   logic isMain;
   logic isFunc;
   logic isInit;
   logic ceHigh;
   logic holdBit;
   logic pdOne;
   logic pdTwo;
   logic refTick;
   logic rfTick;
   logic refPulse;
   logic mainPulse;
   logic pumpEvent;
   logic counterHold;
   logic allSeen;
   logic floatPump;
   logic [31:0] status;
   logic writeNow;
   logic [31:0] ctrl_next;

   psl_shifter shifter
   (
      .clk(clk),
      .resetn(resetn),
      .serialClock(serialClock),
      .serialData(serialData),
      .latchLoadStrobe(latchLoadStrobe),
      .out(wordBus)
   );

   // Latch decode; the select pair sits in the two lowest bits
   assign sel = wordBus.word[1:0];
   assign commitOk = wordBus.commit && ctrl_reg[0];
   assign isRef = commitOk && sel == psl_pkg::SEL_REF; // [RULE_04]
   assign isMain = commitOk && sel == psl_pkg::SEL_MAIN; // [RULE_04]
   assign isFunc = commitOk && sel == psl_pkg::SEL_FUNC; // [RULE_03]
   assign isInit = commitOk && sel == psl_pkg::SEL_INIT; // [RULE_03]

   // Latches are cleared only by resetn, never by the enable pin
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         refLatch_reg <= psl_pkg::LATCH_RESET;
         mainLatch_reg <= psl_pkg::LATCH_RESET;
         funcLatch_reg <= psl_pkg::LATCH_RESET;
         initLatch_reg <= psl_pkg::LATCH_RESET;
      end
      else
      begin
         if (isRef)
            refLatch_reg <= wordBus.word; // [RULE_04] [RULE_12]
         if (isMain)
            mainLatch_reg <= wordBus.word; // [RULE_04]
         if (isFunc || isInit)
            funcLatch_reg <= wordBus.word; // [RULE_03] [RULE_05]
         if (isInit)
            initLatch_reg <= wordBus.word; // [RULE_03]
      end
   end

   assign holdBit = funcLatch_reg[psl_pkg::HOLD_BIT];
   assign pdOne = funcLatch_reg[psl_pkg::PD1_BIT];
   assign pdTwo = funcLatch_reg[psl_pkg::PD2_BIT];

   // Four distinct latches must be written before the pump may drive
   always_ff @(posedge clk)
   begin
      if (!resetn)
         seen_reg <= 4'h0;
      else
         seen_reg <= seen_reg | {isInit, isMain, isRef, isFunc}; // [RULE_19]
   end
   assign allSeen = &seen_reg;

   // Armed by an init load, spent by the first main load after it
   always_ff @(posedge clk)
   begin
      if (!resetn)
         armed_reg <= 1'b0;
      else if (isInit)
         armed_reg <= 1'b1; // [RULE_08]
      else if (isMain)
         armed_reg <= 1'b0; // [RULE_08]
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         resetPulse_reg <= 1'b0;
      else
         resetPulse_reg <= isInit || (isMain && armed_reg); // [RULE_06] [RULE_08]
   end

   // Enable pin and divider inputs are foreign: two stages first
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pinA_reg <= 3'h0;
         pinB_reg <= 3'h0;
         edgePrev_reg <= 2'h0;
      end
      else
      begin
         pinA_reg <= {powerEnable, rfIn, refIn};
         pinB_reg <= pinA_reg;
         edgePrev_reg <= pinB_reg[1:0];
      end
   end
   assign ceHigh = pinB_reg[2];
   assign refTick = pinB_reg[0] && !edgePrev_reg[0];
   assign rfTick = pinB_reg[1] && !edgePrev_reg[1];

   // Counter hold and the reset pulse both force the load point
   assign counterHold = resetPulse_reg || holdBit
      || pwr_reg != psl_pkg::PSL_RUN; // [RULE_06] [RULE_14] [RULE_20]

   psl_divider refDivider
   (
      .clk(clk),
      .resetn(resetn),
      .tick(refTick),
      .hold(counterHold),
      .ratio(refLatch_reg[psl_pkg::REF_LSB +: psl_pkg::CNT_W]),
      .pulse(refPulse)
   );

   psl_divider mainDivider
   (
      .clk(clk),
      .resetn(resetn),
      .tick(rfTick),
      .hold(counterHold),
      .ratio({1'b0, mainLatch_reg[psl_pkg::MAIN_LSB +: psl_pkg::MAIN_W]}),
      .pulse(mainPulse)
   );

   assign pumpEvent = refPulse || mainPulse;

   // Programmed power-down: asynchronous form acts at once, synchronous
   // form waits for a pump event. Counter hold never starts it.
   always_ff @(posedge clk)
   begin
      if (!resetn)
         progDown_reg <= 1'b0;
      else if (!pdOne)
         progDown_reg <= 1'b0;
      else if (!pdTwo)
         progDown_reg <= 1'b1; // [RULE_07]
      else if (pumpEvent)
         progDown_reg <= 1'b1; // [RULE_14]
   end

   // Power state; leaving power-down waits out the bias settle time
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pwr_reg <= psl_pkg::PSL_DOWN;
         settle_reg <= '0;
      end
      else
      begin
         case (pwr_reg)
            psl_pkg::PSL_RUN:
            begin
               if (!ceHigh || progDown_reg)
                  pwr_reg <= psl_pkg::PSL_DOWN; // [RULE_10]
            end
            psl_pkg::PSL_DOWN:
            begin
               if (ceHigh && !progDown_reg)
               begin
                  pwr_reg <= psl_pkg::PSL_SETTLE; // [RULE_11]
                  settle_reg <= psl_pkg::SETTLE_W'(psl_pkg::SETTLE_CYCLES - 1);
               end
            end
            psl_pkg::PSL_SETTLE:
            begin
               if (!ceHigh || progDown_reg)
                  pwr_reg <= psl_pkg::PSL_DOWN; // [RULE_10]
               else if (settle_reg == '0)
                  pwr_reg <= psl_pkg::PSL_RUN; // [RULE_11]
               else
                  settle_reg <= settle_reg - 1'b1;
            end
            default:
               pwr_reg <= psl_pkg::PSL_DOWN;
         endcase
      end
   end

   assign floatPump = funcLatch_reg[psl_pkg::TRI_BIT] || resetPulse_reg
      || holdBit || pwr_reg != psl_pkg::PSL_RUN
      || !allSeen; // [RULE_01] [RULE_06] [RULE_14] [RULE_19]

   // Phase detector: each side latches until the other side arrives
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         up_reg <= 1'b0;
         down_reg <= 1'b0;
      end
      else if (counterHold || ((up_reg || refPulse) && (down_reg || mainPulse)))
      begin
         up_reg <= 1'b0;
         down_reg <= 1'b0;
      end
      else
      begin
         up_reg <= up_reg || refPulse;
         down_reg <= down_reg || mainPulse;
      end
   end

   // Registered pump outputs; polarity bit swaps the two directions
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         pumpUp <= 1'b0;
         pumpDown <= 1'b0;
         highZ_reg <= 1'b1;
         current_reg <= '0;
         poweredDown_reg <= 1'b1;
      end
      else
      begin
         highZ_reg <= floatPump; // [RULE_01]
         poweredDown_reg <= pwr_reg != psl_pkg::PSL_RUN; // [RULE_10]
         pumpUp <= !floatPump && (funcLatch_reg[psl_pkg::POL_BIT]
            ? up_reg : down_reg);
         pumpDown <= !floatPump && (funcLatch_reg[psl_pkg::POL_BIT]
            ? down_reg : up_reg);
         if (mainLatch_reg[psl_pkg::GAIN_BIT])
            current_reg <= funcLatch_reg[psl_pkg::SEC_LSB +: psl_pkg::CUR_W]; // [RULE_02]
         else
            current_reg <= funcLatch_reg[psl_pkg::PRI_LSB +: psl_pkg::CUR_W]; // [RULE_02]
      end
   end

   assign pumpOutputHighZ = highZ_reg;
   assign pumpCurrentCode = current_reg;
   assign poweredDown = poweredDown_reg;

   // AXI4-Lite write: address and data taken in either order
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end
      else
      begin
         if (s_axi_awvalid && awready_reg)
         begin
            awready_reg <= 1'b0;
            awaddr_reg <= s_axi_awaddr;
         end
         else if (bvalid_reg && s_axi_bready)
            awready_reg <= 1'b1;
         if (s_axi_wvalid && wready_reg)
         begin
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         else if (bvalid_reg && s_axi_bready)
            wready_reg <= 1'b1;
      end
   end

   assign writeNow = !awready_reg && !wready_reg && !bvalid_reg;

   always_comb
   begin
      ctrl_next = ctrl_reg;
      for (int i = 0; i < 4; i++)
      begin
         if (wstrb_reg[i])
            ctrl_next[i*8 +: 8] = wdata_reg[i*8 +: 8];
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ctrl_reg <= psl_pkg::CTRL_RESET;
         bvalid_reg <= 1'b0;
         bresp_reg <= psl_pkg::RESP_OKAY;
      end
      else if (writeNow)
      begin
         bvalid_reg <= 1'b1;
         if (awaddr_reg == psl_pkg::OFS_CTRL)
         begin
            ctrl_reg <= {31'h00000000, ctrl_next[0]};
            bresp_reg <= psl_pkg::RESP_OKAY;
         end
         else if (awaddr_reg == psl_pkg::OFS_STATUS
                  || awaddr_reg == psl_pkg::OFS_REF
                  || awaddr_reg == psl_pkg::OFS_MAIN
                  || awaddr_reg == psl_pkg::OFS_FUNC
                  || awaddr_reg == psl_pkg::OFS_INIT)
            bresp_reg <= psl_pkg::RESP_OKAY;
         else
            bresp_reg <= psl_pkg::RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   assign status = {20'h00000, seen_reg, 3'h0,
      pwr_reg == psl_pkg::PSL_SETTLE, armed_reg, allSeen,
      highZ_reg, poweredDown_reg};

   // AXI4-Lite read; one cycle from address to data
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= psl_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && arready_reg)
      begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= psl_pkg::RESP_OKAY;
         if (s_axi_araddr == psl_pkg::OFS_CTRL)
            rdata_reg <= ctrl_reg;
         else if (s_axi_araddr == psl_pkg::OFS_STATUS)
            rdata_reg <= status;
         else if (s_axi_araddr == psl_pkg::OFS_REF)
            rdata_reg <= {8'h00, refLatch_reg};
         else if (s_axi_araddr == psl_pkg::OFS_MAIN)
            rdata_reg <= {8'h00, mainLatch_reg};
         else if (s_axi_araddr == psl_pkg::OFS_FUNC)
            rdata_reg <= {8'h00, funcLatch_reg};
         else if (s_axi_araddr == psl_pkg::OFS_INIT)
            rdata_reg <= {8'h00, initLatch_reg};
         else
         begin
            rdata_reg <= '0;
            rresp_reg <= psl_pkg::RESP_SLVERR;
         end
      end
      else if (rvalid_reg && s_axi_rready)
      begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
endmodule

// File: core/psl_pkg.sv
// Overview of operation
// RULE_01 - Pump three-state bit at 1 floats the pump output; at 0 it drives.
// RULE_02 - Primary current from low three current bits, secondary from upper.
// RULE_03 - Select 1,1 loads initialization latch; 1,0 loads function latch.
// RULE_04 - Select 00 loads reference counter latch; 01 loads main counter latch.
// RULE_05 - An initialization load also rewrites the function latch.
// RULE_06 - Initialization load fires reset pulse: counters to load, pump floated.
// RULE_07 - Enable high, bit one high, bit two low: pulse starts power-down; the code powers down at once, without waiting for a pump event.
// RULE_08 - First main load after initialization refires the pulse, later ones not.
// RULE_09 - Host start-up: init, function, reference, main, counter hold at 0.
// RULE_10 - Power-enable pin low powers the device down at once.
// RULE_11 - Pin start-up: program with enable low, raise it, settle 1 us.
// RULE_12 - Latches keep their contents across power-enable cycles.
// RULE_13 - Host start-up: function hold 1, reference, main, function hold 0.
// RULE_14 - Counter hold holds counters, floats pump, never synchronous power-down.
// RULE_15 - Reference and main dividers accept a ratio of one.
// RULE_16 - Shift on each rising serial clock; strobe rise commits 24 bits.
// RULE_17 - Host keeps serial clock at or below 20 MHz.
// RULE_18 - Host drops strobe, shifts 24 bits, then raises the strobe.
// RULE_19 - Output stays inactive until all four latches are written.
// RULE_20 - Function bit 2 is counter hold: 1 resets counters, 0 counts.
// RULE_21 - Shift register keeps loading and latching during any power-down.
// RULE_22 - Words go most significant bit first; select bits arrive last.
package psl_pkg;
   localparam int WORD_W = 24;
   localparam int CNT_W = 14;
   localparam int CUR_W = 3;
   localparam int MAIN_W = 13;
   localparam logic [1:0] SEL_REF = 2'h0;
   localparam logic [1:0] SEL_MAIN = 2'h1;
   localparam logic [1:0] SEL_FUNC = 2'h2;
   localparam logic [1:0] SEL_INIT = 2'h3;
   localparam int HOLD_BIT = 2;
   localparam int PD1_BIT = 3;
   localparam int POL_BIT = 7;
   localparam int TRI_BIT = 8;
   localparam int PRI_LSB = 15;
   localparam int SEC_LSB = 18;
   localparam int PD2_BIT = 21;
   localparam int REF_LSB = 2;
   localparam int MAIN_LSB = 8;
   localparam int GAIN_BIT = 21;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_REF = 8'h08;
   localparam logic [7:0] OFS_MAIN = 8'h0c;
   localparam logic [7:0] OFS_FUNC = 8'h10;
   localparam logic [7:0] OFS_INIT = 8'h14;
   localparam logic [31:0] CTRL_RESET = 32'h00000001;
   localparam logic [23:0] LATCH_RESET = 24'h000000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int ST_DOWN = 0;
   localparam int ST_HIGHZ = 1;
   localparam int ST_ACTIVE = 2;
   localparam int ST_ARMED = 3;
   localparam int ST_SETTLE = 4;
   localparam int ST_SEEN_LSB = 8;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYCLES = SETTLE_NS / CLK_PERIOD_NS;
   localparam int SETTLE_W = 4;
   typedef enum logic [1:0] {PSL_RUN, PSL_SETTLE, PSL_DOWN} psl_pwr_e;
endpackage

// File: core/psl_shifter.sv
`timescale 1ns/1ps
module psl_shifter
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic serialClock,
   input wire logic serialData,
   input wire logic latchLoadStrobe,
   psl_word_if.src out
);
   logic [2:0] syncA_reg;
   logic [2:0] syncB_reg;
   logic [1:0] prev_reg;
   logic [psl_pkg::WORD_W-1:0] shift_reg;
   logic [psl_pkg::WORD_W-1:0] word_reg;
   logic commit_reg;

   // Pins arrive from another domain: two stages before any use
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         syncA_reg <= 3'h4;
         syncB_reg <= 3'h4;
         prev_reg <= 2'h2;
      end
      else
      begin
         syncA_reg <= {latchLoadStrobe, serialData, serialClock};
         syncB_reg <= syncA_reg;
         prev_reg <= {syncB_reg[2], syncB_reg[0]};
      end
   end

   // Never gated by power state, so words load while powered down
   always_ff @(posedge clk)
   begin
      if (!resetn)
         shift_reg <= psl_pkg::LATCH_RESET;
      else if (syncB_reg[0] && !prev_reg[0])
         shift_reg <= {shift_reg[psl_pkg::WORD_W-2:0], syncB_reg[1]}; // [RULE_16] [RULE_22] [RULE_21]
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         word_reg <= psl_pkg::LATCH_RESET;
         commit_reg <= 1'b0;
      end
      else
      begin
         commit_reg <= syncB_reg[2] && !prev_reg[1]; // [RULE_16]
         if (syncB_reg[2] && !prev_reg[1])
            word_reg <= shift_reg;
      end
   end

   assign out.word = word_reg;
   assign out.commit = commit_reg;
endmodule

// File: core/psl_word_if.sv
`timescale 1ns/1ps
interface psl_word_if;
   logic [psl_pkg::WORD_W-1:0] word;
   logic commit;
   modport src (output word, output commit);
   modport dst (input word, input commit);
endinterface

// File: tb/psl_host_model.sv
`timescale 1ns/1ps
module psl_host_model
(
   output logic serialClock,
   output logic serialData,
   output logic latchLoadStrobe
);
   initial
   begin
      serialClock = 1'b0;
      serialData = 1'b0;
      latchLoadStrobe = 1'b1;
   end
   task automatic send(input logic [23:0] w);
      latchLoadStrobe = 1'b0;
      for (int i = 23; i >= 0; i--)
      begin
         serialData = w[i];
         #400 serialClock = 1'b1;
         #400 serialClock = 1'b0;
      end
      // Inverted so a stale last bit is never taken for fresh data
      serialData = ~w[0];
      #400 latchLoadStrobe = 1'b1;
      #1200;
   endtask
endmodule

// File: tb/psl_loader_chk.sv
`timescale 1ns/1ps
module psl_loader_chk
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic latchLoadStrobe,
   input wire logic powerEnable,
   input wire logic pumpUp,
   input wire logic pumpDown,
   input wire logic pumpOutputHighZ,
   input wire logic [psl_pkg::CUR_W-1:0] pumpCurrentCode,
   input wire logic poweredDown,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready
);
   logic [2:0] commits;
   logic strobeQ;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge clk)
   begin
      strobeQ <= latchLoadStrobe;
      if (!resetn)
         commits <= 3'h0;
      else if (latchLoadStrobe && !strobeQ && commits != 3'h4)
         commits <= commits + 3'h1;
   end
   a_float_quiet: assert property (pumpOutputHighZ |-> !pumpUp && !pumpDown)
      else $error("pump drives while floated");
   a_pin_down: assert property (!powerEnable [*6] |-> poweredDown)
      else $error("enable low without power-down");
   a_pin_float: assert property (!powerEnable [*6] |-> pumpOutputHighZ)
      else $error("enable low with pump driven");
   a_code_steady: assert property (latchLoadStrobe [*8] ##1 latchLoadStrobe
      |-> $stable(pumpCurrentCode))
      else $error("current code moved without a commit");
   a_four_writes: assert property (commits != 3'h4 |-> pumpOutputHighZ)
      else $error("pump active before four loads");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_close: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not withdrawn");
   a_write_close: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid)
      else $error("write answer not withdrawn");
   c_commit: cover property (latchLoadStrobe && !strobeQ);
   c_pin_down: cover property (!powerEnable && poweredDown);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule

// File: tb/psl_loader_top_tb.sv
`timescale 1ns/1ps
module psl_loader_top_tb;
   logic clk, resetn, powerEnable, refIn, rfIn;
   logic serialClock, serialData, latchLoadStrobe;
   logic pumpUp, pumpDown, pumpOutputHighZ, poweredDown;
   logic [psl_pkg::CUR_W-1:0] pumpCurrentCode;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [23:0] fw, rw, mw;
   int mismatches, samplesChecked;
   psl_loader_top psl_loader_top_inst
   (
      .clk, .resetn, .serialClock, .serialData, .latchLoadStrobe,
      .powerEnable, .refIn, .rfIn, .pumpUp, .pumpDown, .pumpOutputHighZ,
      .pumpCurrentCode, .poweredDown, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready
   );
   psl_host_model psl_host_model_inst
   (
      .serialClock, .serialData, .latchLoadStrobe
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      refIn <= ~refIn;
      rfIn <= 1'($urandom);
   end
   task automatic chk(input string n, input logic [31:0] got,
      input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic stop_test;
      if (mismatches == 0 && samplesChecked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic axi(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      logic aw, w;
      @(posedge clk);
      aw = wr;
      w = wr;
      if (wr)
      begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         while (aw || w)
         begin
            @(posedge clk);
            if (aw && s_axi_awready === 1'b1)
            begin
               aw = 1'b0;
               s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1)
            begin
               w = 1'b0;
               s_axi_wvalid <= 1'b0;
            end
         end
         while (s_axi_bvalid !== 1'b1)
            @(posedge clk);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
      else
      begin
         s_axi_araddr <= a;
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
         do
            @(posedge clk);
         while (s_axi_arready !== 1'b1);
         s_axi_arvalid <= 1'b0;
         while (s_axi_rvalid !== 1'b1)
            @(posedge clk);
         q = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      axi(1'b0, a, 32'h0);
   endtask
   task automatic load(input logic [23:0] w, input logic [7:0] a);
      psl_host_model_inst.send(w);
      rd(a);
      chk("latch", q, {8'h0, w});
   endtask
   function automatic logic [23:0] fn(input logic hold, input logic tz);
      logic [23:0] v;
      v = 24'($urandom);
      v[10:8] = {2'h0, tz};
      v[3:2] = {1'b0, hold};
      v[21] = 1'b0;
      v[1:0] = psl_pkg::SEL_FUNC;
      return v;
   endfunction
   function automatic logic [psl_pkg::CUR_W-1:0] cur(input logic [23:0] f,
      input logic [23:0] m);
      return m[21] ? f[20:18] : f[17:15];
   endfunction
   initial
   begin
      #2ms;
      mismatches++;
      stop_test();
   end
   initial
   begin
      void'($urandom(32'hd628da69));
      {resetn, powerEnable, refIn, rfIn} <= 4'h4;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h0;
      {s_axi_arvalid, s_axi_rready} <= 2'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} <= 22'h0;
      s_axi_wdata <= 32'h0;
      s_axi_wstrb <= 4'hf;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      rd(8'h40);
      chk("unmapped", r, psl_pkg::RESP_SLVERR);
      fw = fn(1'b0, 1'b0) | 24'h3;
      load(fw, psl_pkg::OFS_INIT);
      rd(psl_pkg::OFS_FUNC);
      chk("func copy", q, {8'h0, fw});
      rd(psl_pkg::OFS_STATUS);
      chk("armed", q[3], 32'h1);
      chk("early float", pumpOutputHighZ, 32'h1);
      fw = fn(1'b0, 1'b0);
      load(fw, psl_pkg::OFS_FUNC);
      rw = {8'($urandom), 14'h1, 2'h0};
      load(rw, psl_pkg::OFS_REF);
      mw = {3'h0, 13'h1, 6'($urandom), 2'h1};
      load(mw, psl_pkg::OFS_MAIN);
      rd(psl_pkg::OFS_STATUS);
      chk("disarmed", q[3], 32'h0);
      chk("active", pumpOutputHighZ, 32'h0);
      chk("running", poweredDown, 32'h0);
      mw[21] = 1'b1;
      load(mw, psl_pkg::OFS_MAIN);
      chk("gain code", pumpCurrentCode, cur(fw, mw));
      fw = fn(1'b0, 1'b1);
      load(fw, psl_pkg::OFS_FUNC);
      chk("three-state", pumpOutputHighZ, 32'h1);
      load(fn(1'b1, 1'b0), psl_pkg::OFS_FUNC);
      load(rw, psl_pkg::OFS_REF);
      load(mw, psl_pkg::OFS_MAIN);
      chk("hold float", pumpOutputHighZ, 32'h1);
      chk("hold no pd", poweredDown, 32'h0);
      fw = fn(1'b0, 1'b0);
      load(fw, psl_pkg::OFS_FUNC);
      chk("released", pumpOutputHighZ, 32'h0);
      for (int i = 0; i < 8; i++)
      begin
         rw = 24'($urandom) & 24'hfffffc;
         load(rw, psl_pkg::OFS_REF);
         mw = (24'($urandom) & 24'h3ffffc) | 24'h1;
         load(mw, psl_pkg::OFS_MAIN);
         chk("code", pumpCurrentCode, cur(fw, mw));
      end
      powerEnable <= 1'b0;
      repeat (6) @(posedge clk);
      chk("pin down", poweredDown, 32'h1);
      rw = 24'($urandom) & 24'hfffffc;
      load(rw, psl_pkg::OFS_REF);
      powerEnable <= 1'b1;
      repeat (20) @(posedge clk);
      chk("pin up", poweredDown, 32'h0);
      rd(psl_pkg::OFS_MAIN);
      chk("kept", q, {8'h0, mw});
      axi(1'b1, psl_pkg::OFS_CTRL, 32'h0);
      chk("ctrl resp", r, psl_pkg::RESP_OKAY);
      psl_host_model_inst.send(24'h0);
      rd(psl_pkg::OFS_REF);
      chk("refused", q, {8'h0, rw});
      axi(1'b1, 8'h40, 32'h1);
      chk("bad write", r, psl_pkg::RESP_SLVERR);
      axi(1'b1, psl_pkg::OFS_CTRL, 32'h1);
      rd(psl_pkg::OFS_CTRL);
      chk("ctrl", q, psl_pkg::CTRL_RESET);
      stop_test();
   end
endmodule
bind psl_loader_top psl_loader_chk psl_loader_chk_inst
(
   .clk, .resetn, .latchLoadStrobe, .powerEnable, .pumpUp, .pumpDown,
   .pumpOutputHighZ, .pumpCurrentCode, .poweredDown, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid,
   .s_axi_bready
);
